// ---- verilog/uds_host.sv ----
// Firmware-side sequencer driving the USB device OUT and suspend logic
//
// The Wishbone slave port and the placing of the registers were decided locally.
`timescale 1ns/1ps
module uds_host
    import uds_pkg::*;
#(
    parameter int CYC_MS     = uds_pkg::CYC_PER_MS,
    parameter int LOCK_CYCLES = uds_pkg::LOCK_CYC,
    parameter int EP_DEPTH   = uds_pkg::FIFO_DEPTH
) (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [4:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        out_packet_received_flag,
    input  wire logic [7:0]  endpoint_byte_count,
    input  wire logic [7:0]  fifo_data,
    input  wire logic        suspend_detect_flag,
    input  wire logic        bus_wakeup_flag,
    input  wire logic        upstream_resume_active,
    output logic             endpoint_enable,
    output logic      [3:0]  endpoint_select,
    output logic             fifo_read,
    output logic             out_flag_clear,
    output logic             suspend_flag_clear,
    output logic             wakeup_flag_clear,
    output logic             remote_wakeup_enable,
    output logic             send_remote_wakeup,
    output logic             controller_clock_gate,
    output logic             synth_enable,
    output logic             cpu_clock_from_osc
);
    import uds_pkg::*;

    localparam int LW = $clog2(LOCK_CYCLES + 1);

    generate
        if (EP_DEPTH < 1 || EP_DEPTH > 255 || LOCK_CYCLES < 1)
        begin : g_chk
            $error("uds_host parameters out of range");
        end
    endgenerate

    uds_state_t    state_q;
    logic [7:0]    ctrl_q;
    logic [7:0]    count_q;
    logic [7:0]    remain_q;
    logic [7:0]    data_q;
    logic          byte_ready_q;
    logic          asleep_q;
    logic          rw_q;
    logic [2:0]    settle_q;
    logic [LW-1:0] lock_q;
    logic [2:0]    susp_ms_q;
    logic          ms_tick;
    logic          ack_q;
    logic [7:0]    cnt_s;
    logic [7:0]    dat_s;
    logic [3:0]    flg_s;
    logic          outf_s;
    logic          suspf_s;
    logic          wakef_s;
    logic          resact_s;
    logic          wr_stb;
    logic          rd_stb;
    logic          cmd_read;
    logic          cmd_susp;
    logic          cmd_rwake;
    logic [31:0]   rd_mux;

    uds_sync #(.W(8)) u_sync_cnt (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (endpoint_byte_count),
        .q        (cnt_s)
    );

    uds_sync #(.W(8)) u_sync_dat (
        .core_clk (core_clk),
        .reset    (reset),
        .d        (fifo_data),
        .q        (dat_s)
    );

    uds_sync #(.W(4)) u_sync_flg (
        .core_clk (core_clk),
        .reset    (reset),
        .d        ({upstream_resume_active, bus_wakeup_flag,
                    suspend_detect_flag, out_packet_received_flag}),
        .q        (flg_s)
    );

    assign outf_s   = flg_s[0];
    assign suspf_s  = flg_s[1];
    assign wakef_s  = flg_s[2];
    assign resact_s = flg_s[3];

    uds_tick #(.DIV(CYC_MS)) u_ms (
        .core_clk (core_clk),
        .reset    (reset),
        .run      (asleep_q),
        .tick     (ms_tick)
    );

    // Bus slave: ack one cycle after request, effects at the ack edge
    assign wb_ack_o  = ack_q;
    assign wr_stb    = wb_cyc_i && wb_stb_i && ack_q && wb_we_i;
    assign rd_stb    = wb_cyc_i && wb_stb_i && ack_q && !wb_we_i;
    assign cmd_read  = wr_stb && wb_sel_i[0] && wb_adr_i == ADR_CMD && wb_dat_i[CMD_READ];
    assign cmd_susp  = wr_stb && wb_sel_i[0] && wb_adr_i == ADR_CMD && wb_dat_i[CMD_SUSPEND];
    assign cmd_rwake = wr_stb && wb_sel_i[0] && wb_adr_i == ADR_CMD && wb_dat_i[CMD_RWAKE];

    assign endpoint_enable      = ctrl_q[CTRL_EP_EN];
    assign endpoint_select      = ctrl_q[CTRL_EP_LSB +: CTRL_EP_W];
    assign remote_wakeup_enable = ctrl_q[CTRL_RWU];

    always_comb
    begin
        rd_mux = 32'h0000_0000;
        case (wb_adr_i)
            ADR_CTRL:   rd_mux[7:0] = ctrl_q;
            ADR_STATUS:
            begin
                rd_mux[ST_BUSY]    = state_q != S_IDLE;
                rd_mux[ST_ASLEEP]  = asleep_q;
                rd_mux[ST_OUTFLG]  = outf_s;
                rd_mux[ST_SUSPFLG] = suspf_s;
                rd_mux[ST_WAKEFLG] = wakef_s;
                rd_mux[ST_RESACT]  = resact_s;
                rd_mux[ST_BYTERDY] = byte_ready_q;
                rd_mux[ST_STATE_LSB +: 4] = state_q;
            end
            ADR_COUNT:  rd_mux[7:0] = count_q;
            ADR_DATA:   rd_mux[7:0] = data_q;
            default:    rd_mux = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            ack_q    <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
        end
        else
        begin
            ack_q <= wb_cyc_i && wb_stb_i && !ack_q;
            if (wb_cyc_i && wb_stb_i && !ack_q)
                wb_dat_o <= rd_mux;
        end
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            ctrl_q <= CTRL_RESET;
        else if (wr_stb && wb_sel_i[0] && wb_adr_i == ADR_CTRL)
            ctrl_q <= wb_dat_i[7:0];
    end

    // Set by the sequencer wins over a same-cycle data read
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            byte_ready_q <= 1'b0;
        else if (state_q == S_RD_SETTL && settle_q == 3'(SYNC_SETTLE))
            byte_ready_q <= 1'b1;
        else if (rd_stb && wb_adr_i == ADR_DATA)
            byte_ready_q <= 1'b0;
    end

    // Whole milliseconds spent asleep, saturating at the wake minimum
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
            susp_ms_q <= 3'h0;
        else if (!asleep_q)
            susp_ms_q <= 3'h0;
        else if (ms_tick && susp_ms_q < 3'(SUSPEND_MIN_MS))
            susp_ms_q <= susp_ms_q + 3'h1;
    end

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            state_q               <= S_IDLE;
            count_q               <= 8'h00;
            remain_q              <= 8'h00;
            data_q                <= 8'h00;
            settle_q              <= 3'h0;
            lock_q                <= '0;
            rw_q                  <= 1'b0;
            asleep_q              <= 1'b0;
            fifo_read             <= 1'b0;
            out_flag_clear        <= 1'b0;
            suspend_flag_clear    <= 1'b0;
            wakeup_flag_clear     <= 1'b0;
            send_remote_wakeup    <= 1'b0;
            controller_clock_gate <= 1'b0;
            synth_enable          <= 1'b1;
            cpu_clock_from_osc    <= 1'b0;
        end
        else
        begin
            fifo_read          <= 1'b0;
            out_flag_clear     <= 1'b0;
            suspend_flag_clear <= 1'b0;
            wakeup_flag_clear  <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    // Same path for bulk and interrupt endpoints
                    if (cmd_read && endpoint_enable && !asleep_q)
                        state_q <= S_RD_WAIT;
                    else if (cmd_susp && !asleep_q)
                        state_q <= S_SP_CLR;
                    else if (asleep_q && cmd_rwake && remote_wakeup_enable)
                    begin
                        rw_q    <= 1'b1;
                        state_q <= S_WK_LOCK;
                    end
                    else if (asleep_q && wakef_s)
                    begin
                        rw_q    <= 1'b0;
                        state_q <= S_WK_LOCK;
                    end
                end
                S_RD_WAIT:
                begin
                    if (outf_s)
                    begin
                        count_q <= cnt_s;
                        // Overflow bytes never reached the FIFO
                        remain_q <= (cnt_s > 8'(EP_DEPTH)) ? 8'(EP_DEPTH) : cnt_s;
                        state_q  <= (cnt_s == 8'h00) ? S_RD_CLR : S_RD_BYTE;
                    end
                end
                S_RD_BYTE:
                begin
                    fifo_read <= 1'b1;
                    settle_q  <= 3'h0;
                    state_q   <= S_RD_SETTL;
                end
                S_RD_SETTL:
                begin
                    // Data pins pass the synchroniser before they are trusted
                    if (settle_q == 3'(SYNC_SETTLE))
                    begin
                        data_q   <= dat_s;
                        remain_q <= remain_q - 8'h01;
                        state_q  <= S_RD_NEXT;
                    end
                    else
                        settle_q <= settle_q + 3'h1;
                end
                S_RD_NEXT:
                begin
                    if (!byte_ready_q)
                        state_q <= (remain_q == 8'h00) ? S_RD_CLR : S_RD_BYTE;
                end
                S_RD_CLR:
                begin
                    out_flag_clear <= 1'b1;
                    state_q        <= S_RD_DONE;
                end
                S_RD_DONE:
                begin
                    if (!outf_s)
                        state_q <= S_IDLE;
                end
                S_SP_CLR:
                begin
                    suspend_flag_clear <= 1'b1;
                    asleep_q           <= 1'b1;
                    state_q            <= S_SP_GATE;
                end
                S_SP_GATE:
                begin
                    controller_clock_gate <= 1'b1;
                    state_q               <= S_SP_OSC;
                end
                S_SP_OSC:
                begin
                    cpu_clock_from_osc <= 1'b1;
                    state_q            <= S_SP_PLL;
                end
                S_SP_PLL:
                begin
                    synth_enable <= 1'b0;
                    state_q      <= S_IDLE;
                end
                S_WK_LOCK:
                begin
                    synth_enable <= 1'b1;
                    if (lock_q == LW'(LOCK_CYCLES))
                    begin
                        lock_q  <= '0;
                        state_q <= S_WK_RUN;
                    end
                    else
                        lock_q <= lock_q + 1'b1;
                end
                S_WK_RUN:
                begin
                    controller_clock_gate <= 1'b0;
                    cpu_clock_from_osc    <= 1'b0;
                    wakeup_flag_clear     <= !rw_q;
                    state_q               <= S_WK_CLRSP;
                end
                S_WK_CLRSP:
                begin
                    // Remote wake waits out the minimum suspend time
                    if (!rw_q || susp_ms_q >= 3'(SUSPEND_MIN_MS))
                    begin
                        suspend_flag_clear <= 1'b1;
                        asleep_q           <= 1'b0;
                        state_q            <= rw_q ? S_RW_SEND : S_IDLE;
                    end
                end
                S_RW_SEND:
                begin
                    send_remote_wakeup <= 1'b1;
                    if (resact_s)
                        state_q <= S_RW_END;
                end
                S_RW_END:
                begin
                    if (!resact_s)
                    begin
                        send_remote_wakeup <= 1'b0;
                        rw_q               <= 1'b0;
                        state_q            <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end

    sequence s_enter;
        suspend_flag_clear ##1 controller_clock_gate ##1 cpu_clock_from_osc ##1 !synth_enable;
    endsequence

    property p_suspend_entry;
        @(posedge core_clk) disable iff (reset)
        state_q == S_SP_CLR |=> s_enter;
    endproperty
    a_suspend_entry: assert property (p_suspend_entry)
        else $error("suspend entry order broken");

    property p_pll_last;
        @(posedge core_clk) disable iff (reset)
        $fell(synth_enable) |-> controller_clock_gate && cpu_clock_from_osc;
    endproperty
    a_pll_last: assert property (p_pll_last)
        else $error("synth stopped before clock gate or osc select");

    property p_rwu_gate;
        @(posedge core_clk) disable iff (reset)
        $rose(send_remote_wakeup) |-> remote_wakeup_enable;
    endproperty
    a_rwu_gate: assert property (p_rwu_gate)
        else $error("wake sent without remote wakeup enable");

    property p_wake_order;
        @(posedge core_clk) disable iff (reset)
        $rose(send_remote_wakeup) |-> synth_enable && !controller_clock_gate
            && $past(suspend_flag_clear);
    endproperty
    a_wake_order: assert property (p_wake_order)
        else $error("wake sent before clocks on and suspend cleared");

    property p_wake_5ms;
        @(posedge core_clk) disable iff (reset)
        suspend_flag_clear && rw_q |-> susp_ms_q >= 3'(SUSPEND_MIN_MS);
    endproperty
    a_wake_5ms: assert property (p_wake_5ms)
        else $error("remote wake before 5 ms of suspend");

    property p_send_clear;
        @(posedge core_clk) disable iff (reset)
        $fell(send_remote_wakeup) |-> $past(state_q) == S_RW_END && !$past(resact_s);
    endproperty
    a_send_clear: assert property (p_send_clear)
        else $error("send bit cleared while resume still active");

    property p_out_clear;
        @(posedge core_clk) disable iff (reset)
        out_flag_clear |-> remain_q == 8'h00 && !byte_ready_q;
    endproperty
    a_out_clear: assert property (p_out_clear)
        else $error("OUT flag cleared before all bytes read");

    property p_zlp;
        @(posedge core_clk) disable iff (reset)
        state_q == S_RD_WAIT && outf_s && cnt_s == 8'h00 |=> !fifo_read ##1 out_flag_clear;
    endproperty
    a_zlp: assert property (p_zlp)
        else $error("zero length packet not cleared without reads");

    property p_resume_order;
        @(posedge core_clk) disable iff (reset)
        $fell(controller_clock_gate) |-> synth_enable && $past(state_q) == S_WK_RUN;
    endproperty
    a_resume_order: assert property (p_resume_order)
        else $error("clock ungated before synth restarted");

    property p_ep_enabled;
        @(posedge core_clk) disable iff (reset)
        state_q == S_IDLE ##1 state_q == S_RD_WAIT |-> endpoint_enable;
    endproperty
    a_ep_enabled: assert property (p_ep_enabled)
        else $error("read started on disabled endpoint");
endmodule

// ---- verilog/uds_pkg.sv ----
// Constants and types for the USB device OUT and suspend controller
package uds_pkg;

    localparam int CLK_NS         = 20;
    localparam int MS_NS          = 1_000_000;
    localparam int US_NS          = 1_000;
    localparam int SUSPEND_MIN_MS = 5;
    localparam int CYC_PER_MS     = MS_NS / CLK_NS;
    localparam int SYNTH_LOCK_US  = 100;
    localparam int LOCK_CYC       = (SYNTH_LOCK_US * US_NS) / CLK_NS;
    // Registered FIFO output plus four sync stages: sample one cycle after q moves
    localparam int SYNC_SETTLE    = 5;
    localparam int FIFO_DEPTH     = 64;

    localparam logic [4:0] ADR_CTRL   = 5'h00;
    localparam logic [4:0] ADR_CMD    = 5'h04;
    localparam logic [4:0] ADR_STATUS = 5'h08;
    localparam logic [4:0] ADR_COUNT  = 5'h0C;
    localparam logic [4:0] ADR_DATA   = 5'h10;

    localparam int CTRL_EP_EN  = 0;
    localparam int CTRL_RWU    = 1;
    localparam int CTRL_EP_LSB = 4;
    localparam int CTRL_EP_W   = 4;
    localparam logic [7:0] CTRL_RESET = 8'h00;

    localparam int CMD_READ    = 0;
    localparam int CMD_SUSPEND = 1;
    localparam int CMD_RWAKE   = 2;

    localparam int ST_BUSY    = 0;
    localparam int ST_ASLEEP  = 1;
    localparam int ST_OUTFLG  = 2;
    localparam int ST_SUSPFLG = 3;
    localparam int ST_WAKEFLG = 4;
    localparam int ST_RESACT  = 5;
    localparam int ST_BYTERDY = 6;
    localparam int ST_STATE_LSB = 8;

    typedef enum logic [3:0] {
        S_IDLE     = 4'b0000,
        S_RD_WAIT  = 4'b0001,
        S_RD_BYTE  = 4'b0010,
        S_RD_SETTL = 4'b0011,
        S_RD_NEXT  = 4'b0100,
        S_RD_CLR   = 4'b0101,
        S_RD_DONE  = 4'b0110,
        S_SP_CLR   = 4'b0111,
        S_SP_GATE  = 4'b1000,
        S_SP_OSC   = 4'b1001,
        S_SP_PLL   = 4'b1010,
        S_WK_LOCK  = 4'b1011,
        S_WK_RUN   = 4'b1100,
        S_WK_CLRSP = 4'b1101,
        S_RW_SEND  = 4'b1110,
        S_RW_END   = 4'b1111
    } uds_state_t;

endpackage

// ---- verilog/uds_sync.sv ----
// Three-stage pin synchroniser with agreement filter
`timescale 1ns/1ps
module uds_sync #(
    parameter int W = 1
) (
    input  wire logic         core_clk,
    input  wire logic         reset,
    input  wire logic [W-1:0] d,
    output logic      [W-1:0] q
);
    logic [W-1:0] s1_q;
    logic [W-1:0] s2_q;
    logic [W-1:0] s3_q;

    generate
        if (W < 1)
        begin : g_chk
            $error("uds_sync width must be at least 1");
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            s1_q <= '0;
            s2_q <= '0;
            s3_q <= '0;
            q    <= '0;
        end
        else
        begin
            s1_q <= d;
            s2_q <= s1_q;
            s3_q <= s2_q;
            // Only a value seen twice in a row is passed on
            if (s2_q == s3_q)
                q <= s3_q;
        end
    end
endmodule

// ---- verilog/uds_tick.sv ----
// Enable-pulse divider: one pulse every DIV cycles while running
`timescale 1ns/1ps
module uds_tick #(
    parameter int DIV = 50000
) (
    input  wire logic core_clk,
    input  wire logic reset,
    input  wire logic run,
    output logic      tick
);
    localparam int CW = $clog2(DIV);

    logic [CW-1:0] cnt_q;

    generate
        if (DIV < 2)
        begin : g_chk
            $error("uds_tick divide ratio must be at least 2");
        end
    endgenerate

    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (!run)
        begin
            cnt_q <= '0;
            tick  <= 1'b0;
        end
        else if (cnt_q == CW'(DIV - 1))
        begin
            cnt_q <= '0;
            tick  <= 1'b1;
        end
        else
        begin
            cnt_q <= cnt_q + 1'b1;
            tick  <= 1'b0;
        end
    end
endmodule

// ---- test/uds_dev.sv ----
// Device model: OUT endpoint FIFO, suspend timer, wake and resume flags
`timescale 1ns/1ps
module uds_dev #(
    parameter int IDLE_CYC = 150,
    parameter int DEPTH    = 4,
    parameter int RES_CYC  = 12
) (
    input  wire logic       core_clk,
    input  wire logic       reset,
    input  wire logic       pkt_go,
    input  wire logic [7:0] pkt_len,
    input  wire logic [7:0] pkt_base,
    input  wire logic       bus_active,
    input  wire logic       fifo_read,
    input  wire logic       out_flag_clear,
    input  wire logic       suspend_flag_clear,
    input  wire logic       wakeup_flag_clear,
    input  wire logic       send_remote_wakeup,
    input  wire logic       controller_clock_gate,
    output logic            out_packet_received_flag,
    output logic      [7:0] endpoint_byte_count,
    output logic      [7:0] fifo_data,
    output logic            suspend_detect_flag,
    output logic            bus_wakeup_flag,
    output logic            upstream_resume_active
);
    logic [7:0] mem_q [DEPTH];
    logic [7:0] ptr_q;
    logic       pad_idle_q;
    int         idle_q;
    int         res_q;
    // Same path for bulk and interrupt; a busy endpoint NAKs the packet
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            out_packet_received_flag <= 1'b0;
            endpoint_byte_count <= 8'h00;
            ptr_q <= 8'h00;
            fifo_data <= 8'h00;
        end
        else if (pkt_go && !out_packet_received_flag)
        begin
            out_packet_received_flag <= 1'b1;
            endpoint_byte_count <= pkt_len;
            ptr_q <= 8'h00;
            for (int i = 0; i < DEPTH; i++)
                mem_q[i] <= (i < pkt_len) ? pkt_base + 8'(i) : 8'h00;
        end
        else if (out_flag_clear)
            out_packet_received_flag <= 1'b0;
        else if (fifo_read)
        begin
            fifo_data <= mem_q[ptr_q];
            ptr_q <= ptr_q + 8'h01;
        end
    end
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset)
        begin
            idle_q <= 0;
            suspend_detect_flag <= 1'b0;
            pad_idle_q <= 1'b0;
            bus_wakeup_flag <= 1'b0;
        end
        else
        begin
            // Gated clock stops the timer, so no fresh detection
            if (pkt_go || bus_active || controller_clock_gate || suspend_flag_clear)
                idle_q <= 0;
            else if (idle_q <= IDLE_CYC)
                idle_q <= idle_q + 1;
            if (idle_q == IDLE_CYC)
                suspend_detect_flag <= 1'b1;
            else if (suspend_flag_clear)
                suspend_detect_flag <= 1'b0;
            if (suspend_flag_clear)
                pad_idle_q <= 1'b1;
            else if (bus_active || send_remote_wakeup)
                pad_idle_q <= 1'b0;
            if (bus_active && pad_idle_q)
                bus_wakeup_flag <= 1'b1;
            else if (wakeup_flag_clear)
                bus_wakeup_flag <= 1'b0;
        end
    end
    always_ff @(posedge core_clk or posedge reset)
    begin
        if (reset || !send_remote_wakeup)
            res_q <= 0;
        else if (res_q < RES_CYC)
            res_q <= res_q + 1;
    end
    assign upstream_resume_active = send_remote_wakeup && res_q > 0 && res_q < RES_CYC;
endmodule

// ---- test/uds_host_bench.sv ----
// Bench for the OUT and suspend sequencer against the device model
`timescale 1ns/1ps
module uds_host_bench;
    import uds_pkg::*;
    typedef struct packed {logic [31:0] d; logic [31:0] m;} uds_note_t;
    logic core_clk, reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o, pkt_go, bus_active;
    logic [4:0]  wb_adr_i;
    logic [3:0]  wb_sel_i, endpoint_select;
    logic [31:0] wb_dat_i, wb_dat_o, rd;
    logic [7:0]  endpoint_byte_count, fifo_data, pkt_len, pkt_base, base;
    logic out_packet_received_flag, suspend_detect_flag, bus_wakeup_flag, upstream_resume_active;
    logic endpoint_enable, fifo_read, out_flag_clear, suspend_flag_clear, wakeup_flag_clear;
    logic remote_wakeup_enable, send_remote_wakeup, controller_clock_gate, synth_enable;
    logic cpu_clock_from_osc, res_seen;
    int num_errors, tests_run, pops, p0, seed, t_sleep, t_send, waited;
    int lens[3] = '{6, 3, 0};
    uds_note_t exp_q[$];
    uds_note_t note;
    uds_host #(.CYC_MS(20), .LOCK_CYCLES(8), .EP_DEPTH(4)) dut_u (.*);
    uds_dev #(.IDLE_CYC(150), .DEPTH(4), .RES_CYC(12)) dev_u (.*);
    initial
    begin
        core_clk = 1'b0;
        forever #10 core_clk = ~core_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] want);
        tests_run++;
        if (seen !== want)
        begin
            num_errors++;
            $display("mismatch t=%0t seen=%h want=%h", $time, seen, want);
        end
    endtask
    task automatic report_and_stop();
        $display("checks=%0d errors=%0d", tests_run, num_errors);
        if (num_errors == 0 && tests_run > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // For reads d is the expected value under mask m
    task automatic wb(input logic we, input logic [4:0] a, input logic [31:0] d,
                      input logic [31:0] m);
        @(posedge core_clk);
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= a;
        // Random lanes; writes keep the low lane that carries every field
        wb_sel_i <= 4'($random(seed)) | {3'h0, we};
        wb_dat_i <= we ? d : 32'h0000_0000;
        if (!we)
            exp_q.push_back('{d, m});
        do
            @(posedge core_clk);
        while (wb_ack_o !== 1'b1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
    endtask
    task automatic poll(input int b, input logic v);
        waited = 0;
        do
        begin
            wb(1'b0, ADR_STATUS, 32'h0000_0000, 32'h0000_0000);
            waited++;
        end
        while (rd[b] !== v && waited < 3000);
        check({31'h0, rd[b]}, {31'h0, v});
    endtask
    // Read answers are matched in order of issue
    always @(posedge core_clk)
    begin
        if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && exp_q.size() > 0)
        begin
            note = exp_q.pop_front();
            if (note.m != 0)
                check(wb_dat_o & note.m, note.d);
        end
        pops <= pops + (fifo_read === 1'b1 ? 1 : 0);
        t_sleep <= (controller_clock_gate === 1'b1 && cpu_clock_from_osc === 1'b0) ? 0 : t_sleep + 1;
        if (send_remote_wakeup === 1'b1 && t_send == 0)
            t_send <= t_sleep;
        if (upstream_resume_active === 1'b1)
            res_seen <= 1'b1;
    end
    initial
    begin
        seed = 32'hc75e_a1c1;
        {num_errors, tests_run, pops, t_sleep, t_send, res_seen} = '0;
        {reset, wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = {1'b1, 40'h0};
        {pkt_go, bus_active, pkt_len, pkt_base, wb_sel_i} = {18'h0, 4'hf};
        repeat (20) @(posedge core_clk);
        reset <= 1'b0;
        check({31'h0, synth_enable}, 32'h0000_0001);
        wb(1'b0, 5'h14, 32'h0000_0000, 32'hffff_ffff);
        wb(1'b1, ADR_CTRL, 32'h0000_0031, 32'h0000_0000);
        wb(1'b0, ADR_CTRL, 32'h0000_0031, 32'hffff_ffff);
        check({27'h0, endpoint_enable, endpoint_select}, 32'h0000_0013);
        foreach (lens[k])
        begin
            base = 8'($random(seed));
            pkt_base <= base;
            pkt_len <= 8'(lens[k]);
            pkt_go <= 1'b1;
            @(posedge core_clk);
            pkt_len <= 8'h09;
            pkt_base <= ~base;
            @(posedge core_clk);
            pkt_go <= 1'b0;
            p0 = pops;
            wb(1'b1, ADR_CMD, 32'h0000_0001, 32'h0000_0000);
            for (int i = 0; i < lens[k] && i < 4; i++)
            begin
                poll(ST_BYTERDY, 1'b1);
                wb(1'b0, ADR_DATA, {24'h0, base + 8'(i)}, 32'h0000_00ff);
            end
            poll(ST_BUSY, 1'b0);
            wb(1'b0, ADR_COUNT, 32'(lens[k]), 32'h0000_00ff);
            check(32'(pops - p0), 32'(lens[k] < 4 ? lens[k] : 4));
            check({31'h0, out_packet_received_flag}, 32'h0000_0000);
        end
        poll(ST_SUSPFLG, 1'b1);
        wb(1'b1, ADR_CMD, 32'h0000_0002, 32'h0000_0000);
        poll(ST_BUSY, 1'b0);
        check({29'h0, controller_clock_gate, cpu_clock_from_osc, synth_enable}, 32'h6);
        repeat (200) @(posedge core_clk);
        wb(1'b0, ADR_STATUS, 32'h0000_0002, 32'h0000_000a);
        bus_active <= 1'b1;
        @(posedge core_clk);
        bus_active <= 1'b0;
        poll(ST_ASLEEP, 1'b0);
        check({29'h0, controller_clock_gate, cpu_clock_from_osc, synth_enable}, 32'h1);
        check({31'h0, bus_wakeup_flag}, 32'h0000_0000);
        poll(ST_SUSPFLG, 1'b0);
        wb(1'b1, ADR_CTRL, 32'h0000_0033, 32'h0000_0000);
        // The write lands at the ack edge; look once it has settled
        @(posedge core_clk);
        check({31'h0, remote_wakeup_enable}, 32'h0000_0001);
        wb(1'b1, ADR_CMD, 32'h0000_0002, 32'h0000_0000);
        poll(ST_ASLEEP, 1'b1);
        wb(1'b1, ADR_CMD, 32'h0000_0004, 32'h0000_0000);
        poll(ST_BUSY, 1'b0);
        check({31'h0, send_remote_wakeup}, 32'h0000_0000);
        check({31'h0, res_seen}, 32'h0000_0001);
        check({31'h0, t_send >= 99}, 32'h0000_0001);
        report_and_stop();
    end
    // Whole run needs well under this many cycles
    initial
    begin
        repeat (60000) @(posedge core_clk);
        num_errors++;
        report_and_stop();
    end
endmodule
